// *** include/bfm_regs.svh ***
// Register offsets, field positions, reset values and masks of the bidirectional queue flag block.
// Assumes a byte-addressed register port with one 32-bit word per register.
`ifndef BFM_REGS_SVH
`define BFM_REGS_SVH
`define BFM_ADDR_CFG      8'h00
`define BFM_ADDR_OFFS     8'h04
`define BFM_ADDR_STATUS   8'h08
`define BFM_ADDR_INT_STAT 8'h0c
`define BFM_ADDR_INT_CLR  8'h10
`define BFM_ADDR_INT_EN   8'h14
`define BFM_CFG_FALLTHRU  0
`define BFM_CFG_DEPTH_LO  1
`define BFM_CFG_DEPTH_HI  2
`define BFM_CFG_RST       3'h4
`define BFM_OFFS_RST      16'h0808
`define BFM_DEPTH_256     11'h100
`define BFM_DEPTH_512     11'h200
`define BFM_DEPTH_1024    11'h400
`define BFM_INT_W         4
`define BFM_WORD_MASK     36'h0_0003_ffff
`define BFM_BYTE_MASK     36'h0_0000_01ff
`define BFM_LONG_MASK     36'hf_ffff_ffff
`endif

// *** include/bfm_pkg.sv ***
// Types shared by the bidirectional queue flag block.
// Assumes the constants header is included by the design files that need numbers.
package bfm_pkg;
  typedef enum logic [1:0] {BFM_LONG, BFM_WORD, BFM_BYTE} bfm_size_t;
  typedef struct packed {
    logic        clk;
    logic        csN;
    logic        dir;
    logic        mb;
    logic [35:0] data;
  } bfm_pins_t;
  typedef struct packed {
    logic full;
    logic almostFull;
    logic almostEmpty;
    logic empty;
  } bfm_qflags_t;
endpackage

// *** core/bfm_queue_flags.sv ***
// Occupancy tracking and flags of one queue, counted in long words.
// Assumes writer and reader events are one-cycle pulses on ref_clk, each tied to its port's clock edge.
`timescale 1ns/10ps
`default_nettype none
module bfm_queue_flags (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst,
  // Writer side
  input  wire logic               wrEdge,
  input  wire logic               wrPush,
  // Reader side
  input  wire logic               rdEdge,
  input  wire logic               rdPop,
  // Thresholds
  input  wire logic [10:0]        depth,
  input  wire logic [7:0]         aeOffset,
  input  wire logic [7:0]         afOffset,
  // Flags
  output bfm_pkg::bfm_qflags_t    flags
);
  logic [10:0] wrCount, rdCount, wrSyncA, wrSyncB, rdSyncA, rdSyncB;
  logic [10:0] next_wrCount, next_rdCount, wrLevel, rdLevel;
  bfm_pkg::bfm_qflags_t next_flags;

  // The far pointer reaches each side only through two stages, so a flag may lag by one port edge.
  always_comb
  begin
    next_wrCount = wrCount + 11'(wrPush);
    next_rdCount = rdCount + 11'(rdPop);
    wrLevel      = next_wrCount - rdSyncB; // see (R14)
    rdLevel      = wrSyncB - next_rdCount; // see (R14)
    next_flags   = flags;
    if (wrEdge)
    begin
      next_flags.full       = wrLevel >= depth; // see (R9)
      next_flags.almostFull = wrLevel >= depth - {3'h0, afOffset}; // see (R9) see (R8)
    end
    if (rdEdge)
    begin
      next_flags.almostEmpty = rdLevel <= {3'h0, aeOffset}; // see (R4) see (R6)
      next_flags.empty       = rdLevel == 11'h000;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wrCount <= 11'h000;
      rdCount <= 11'h000;
      wrSyncA <= 11'h000;
      wrSyncB <= 11'h000;
      rdSyncA <= 11'h000;
      rdSyncB <= 11'h000;
      flags   <= 4'h3;
    end
    else
    begin
      wrCount <= next_wrCount;
      rdCount <= next_rdCount;
      wrSyncA <= wrCount;
      wrSyncB <= wrSyncA;
      rdSyncA <= rdCount;
      rdSyncB <= rdSyncA;
      flags   <= next_flags;
    end
  end
endmodule
`default_nettype wire

// *** core/bfm_top.sv ***
// Flag and mailbox logic of a two-port bidirectional queue device, one queue per direction.
// Assumes both port clocks arrive as pins far slower than ref_clk; every pin passes two flip-flops.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "bfm_regs.svh"
// Overview of operation
// (R1) In fall-through mode port B input-ready rises on the next port B edge after space frees, or one edge later.
// (R2) In standard mode the port B full flag drops on the next port B edge after space frees, or one edge later.
// (R3) With word or byte size on port B only the write completing a long word changes the queue count.
// (R4) Port B almost-empty releases on the next port B edge after port A fills the queue, or one later.
// (R5) With word or byte size the port B almost-empty flag asserts only on the read completing a long word.
// (R6) Port A almost-empty releases on the next port A edge after long-word writes on port B, or one later.
// (R7) Port A almost-full releases on the next port A edge after port B long-word reads drain the queue.
// (R8) Port B almost-full releases on the next port B edge and asserts only on a completing long-word write.
// (R9) Almost-full thresholds are measured from a queue depth of 256, 512 or 1024 entries.
// (R10) The other party writes port B and reads port A with chip select, direction and mailbox select low.
// (R11) The A-to-B mailbox carries bits 0-17 in word size and bits 0-8 in byte size.
// (R12) The B-to-A mailbox carries bits 0-17 in word size and bits 0-8 in byte size.
// (R13) The other party keeps the bus match and size selects static during operation.
// (R14) Each flag sees the far pointer through a two-stage synchroniser into its owner's side.
// (R15) A mailbox full flag sets on the sender's write and clears on the receiver's read.
module bfm_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdData,
  output logic             irq,
  // Port A pins
  input  wire logic        portaClock,
  input  wire logic        portaChipSelectN,
  input  wire logic        portaDirectionSelect,
  input  wire logic        portaMailboxSelect,
  input  wire logic [35:0] portaData,
  output logic [35:0]      portaMailData,
  output logic             portaAlmostEmpty,
  output logic             portaAlmostFull,
  output logic             bToAMailFull,
  // Port B pins
  input  wire logic        portbClock,
  input  wire logic        portbChipSelectN,
  input  wire logic        portbDirectionSelect,
  input  wire logic        portbMailboxSelect,
  input  wire logic        busMatchSelect,
  input  wire logic        portbSizeSelect,
  input  wire logic [35:0] portbData,
  output logic [35:0]      portbMailData,
  output logic             portbInputReady,
  output logic             portbFullFlag,
  output logic             portbAlmostEmpty,
  output logic             portbAlmostFull,
  output logic             aToBMailFull
);
  bfm_pkg::bfm_pins_t   aSync1, aSync2, bSync1, bSync2;
  logic [1:0]           sizeSync1, sizeSync2;
  logic                 aClkPrev, bClkPrev;
  logic                 aEdge, bEdge;
  bfm_pkg::bfm_size_t   bSize;
  logic [1:0]           lastIdx, wrPiece, rdPiece, next_wrPiece, next_rdPiece;
  logic [35:0]          mailMask;
  logic                 aWrite, aRead, aMailWr, aMailRd;
  logic                 bWrite, bRead, bMailWr, bMailRd;
  logic                 abPush, abPop, baPush, baPop;
  bfm_pkg::bfm_qflags_t abFlags, baFlags;
  logic [35:0]          abMail, baMail, next_abMail, next_baMail;
  logic [35:0]          next_portaMailData, next_portbMailData;
  logic                 next_aToBMailFull, next_bToAMailFull;
  logic [2:0]           cfg, next_cfg;
  logic [15:0]          offs, next_offs;
  logic [`BFM_INT_W-1:0] intStat, intEn, next_intStat, next_intEn, events;
  logic [1:0]           fullPrev;
  logic [31:0]          next_regRdData;
  logic [10:0]          depth;

  // Pins are sampled twice before use; the port clocks become edge strobes on ref_clk.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      aSync1    <= '0;
      aSync2    <= '0;
      bSync1    <= '0;
      bSync2    <= '0;
      sizeSync1 <= 2'h0;
      sizeSync2 <= 2'h0;
      aClkPrev  <= 1'b0;
      bClkPrev  <= 1'b0;
    end
    else
    begin
      aSync1    <= {portaClock, portaChipSelectN, portaDirectionSelect, portaMailboxSelect, portaData};
      aSync2    <= aSync1;
      bSync1    <= {portbClock, portbChipSelectN, portbDirectionSelect, portbMailboxSelect, portbData};
      bSync2    <= bSync1;
      sizeSync1 <= {busMatchSelect, portbSizeSelect};
      sizeSync2 <= sizeSync1;
      aClkPrev  <= aSync2.clk;
      bClkPrev  <= bSync2.clk;
    end
  end

  assign aEdge = aSync2.clk & ~aClkPrev;
  assign bEdge = bSync2.clk & ~bClkPrev;

  // Size is sampled live; a change in mid long word is the controller's fault and is not repaired.
  always_comb
  begin
    if (!sizeSync2[1])
      bSize = bfm_pkg::BFM_LONG;
    else if (sizeSync2[0])
      bSize = bfm_pkg::BFM_BYTE;
    else
      bSize = bfm_pkg::BFM_WORD;
  end

  always_comb
  begin
    case (bSize)
      bfm_pkg::BFM_WORD:
      begin
        lastIdx  = 2'h1;
        mailMask = `BFM_WORD_MASK; // see (R11) see (R12)
      end
      bfm_pkg::BFM_BYTE:
      begin
        lastIdx  = 2'h3;
        mailMask = `BFM_BYTE_MASK; // see (R11) see (R12)
      end
      default:
      begin
        lastIdx  = 2'h0;
        mailMask = `BFM_LONG_MASK;
      end
    endcase
  end

  // Port A writes with direction high and reads with it low; port B the other way round.
  assign aWrite  = aEdge & ~aSync2.csN & aSync2.dir & ~aSync2.mb;
  assign aRead   = aEdge & ~aSync2.csN & ~aSync2.dir & ~aSync2.mb; // see (R10)
  assign aMailWr = aEdge & ~aSync2.csN & aSync2.dir & aSync2.mb;
  assign aMailRd = aEdge & ~aSync2.csN & ~aSync2.dir & aSync2.mb;
  assign bWrite  = bEdge & ~bSync2.csN & ~bSync2.dir & ~bSync2.mb; // see (R10)
  assign bRead   = bEdge & ~bSync2.csN & bSync2.dir & ~bSync2.mb;
  assign bMailWr = bEdge & ~bSync2.csN & ~bSync2.dir & bSync2.mb;
  assign bMailRd = bEdge & ~bSync2.csN & bSync2.dir & bSync2.mb;

  // Only the piece that completes a long word moves a pointer; earlier pieces leave flags alone.
  assign abPush = aWrite & ~abFlags.full;
  assign abPop  = bRead & ~abFlags.empty & (rdPiece == lastIdx); // see (R5) see (R7)
  assign baPush = bWrite & ~baFlags.full & (wrPiece == lastIdx); // see (R3) see (R8)
  assign baPop  = aRead & ~baFlags.empty;

  always_comb
  begin
    next_wrPiece = wrPiece;
    next_rdPiece = rdPiece;
    if (bWrite & ~baFlags.full)
      next_wrPiece = (wrPiece == lastIdx) ? 2'h0 : wrPiece + 2'h1; // see (R3)
    if (bRead & ~abFlags.empty)
      next_rdPiece = (rdPiece == lastIdx) ? 2'h0 : rdPiece + 2'h1; // see (R5)
  end

  always_comb
  begin
    case (cfg[`BFM_CFG_DEPTH_HI:`BFM_CFG_DEPTH_LO])
      2'h0: depth = `BFM_DEPTH_256; // see (R9)
      2'h1: depth = `BFM_DEPTH_512;
      default: depth = `BFM_DEPTH_1024;
    endcase
  end

  bfm_queue_flags u_ab_queue (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .wrEdge   (aEdge),
    .wrPush   (abPush),
    .rdEdge   (bEdge),
    .rdPop    (abPop),
    .depth    (depth),
    .aeOffset (offs[7:0]),
    .afOffset (offs[15:8]),
    .flags    (abFlags)
  );

  bfm_queue_flags u_ba_queue (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .wrEdge   (bEdge),
    .wrPush   (baPush),
    .rdEdge   (aEdge),
    .rdPop    (baPop),
    .depth    (depth),
    .aeOffset (offs[7:0]),
    .afOffset (offs[15:8]),
    .flags    (baFlags)
  );

  assign portbInputReady  = cfg[`BFM_CFG_FALLTHRU] & ~baFlags.full; // see (R1)
  assign portbFullFlag    = ~cfg[`BFM_CFG_FALLTHRU] & baFlags.full; // see (R2)
  assign portbAlmostFull  = baFlags.almostFull; // see (R8)
  assign portbAlmostEmpty = abFlags.almostEmpty; // see (R4) see (R5)
  assign portaAlmostFull  = abFlags.almostFull; // see (R7)
  assign portaAlmostEmpty = baFlags.almostEmpty; // see (R6)

  // Mailboxes bypass the queues; a write landing with the read in one cycle keeps the flag set.
  always_comb
  begin
    next_abMail        = aMailWr ? (aSync2.data & mailMask) : abMail; // see (R11)
    next_baMail        = bMailWr ? (bSync2.data & mailMask) : baMail; // see (R12)
    next_portbMailData = bMailRd ? abMail : portbMailData; // see (R11)
    next_portaMailData = aMailRd ? baMail : portaMailData; // see (R12)
    next_aToBMailFull  = aMailWr | (aToBMailFull & ~bMailRd); // see (R15)
    next_bToAMailFull  = bMailWr | (bToAMailFull & ~aMailRd); // see (R15)
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      wrPiece       <= 2'h0;
      rdPiece       <= 2'h0;
      abMail        <= 36'h0;
      baMail        <= 36'h0;
      portaMailData <= 36'h0;
      portbMailData <= 36'h0;
      aToBMailFull  <= 1'b0;
      bToAMailFull  <= 1'b0;
    end
    else
    begin
      wrPiece       <= next_wrPiece;
      rdPiece       <= next_rdPiece;
      abMail        <= next_abMail;
      baMail        <= next_baMail;
      portaMailData <= next_portaMailData;
      portbMailData <= next_portbMailData;
      aToBMailFull  <= next_aToBMailFull;
      bToAMailFull  <= next_bToAMailFull;
    end
  end

  // Events: mail arrival each way and a queue turning full each way. Set beats clear.
  assign events = {baFlags.full & ~fullPrev[1], abFlags.full & ~fullPrev[0], bMailWr, aMailWr};

  always_comb
  begin
    next_cfg       = cfg;
    next_offs      = offs;
    next_intEn     = intEn;
    next_intStat   = intStat | events;
    next_regRdData = 32'h0;
    if (regWr)
    begin
      if (regAddr == `BFM_ADDR_CFG)
        next_cfg = regWrData[2:0];
      else if (regAddr == `BFM_ADDR_OFFS)
        next_offs = regWrData[15:0];
      else if (regAddr == `BFM_ADDR_INT_CLR)
        next_intStat = (intStat & ~regWrData[`BFM_INT_W-1:0]) | events;
      else if (regAddr == `BFM_ADDR_INT_EN)
        next_intEn = regWrData[`BFM_INT_W-1:0];
    end
    if (regRd)
    begin
      if (regAddr == `BFM_ADDR_CFG)
        next_regRdData = {29'h0, cfg};
      else if (regAddr == `BFM_ADDR_OFFS)
        next_regRdData = {16'h0, offs};
      else if (regAddr == `BFM_ADDR_STATUS)
        next_regRdData = {24'h0, bToAMailFull, aToBMailFull, baFlags, abFlags[3:2]};
      else if (regAddr == `BFM_ADDR_INT_STAT)
        next_regRdData = {28'h0, intStat};
      else if (regAddr == `BFM_ADDR_INT_EN)
        next_regRdData = {28'h0, intEn};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg       <= `BFM_CFG_RST;
      offs      <= `BFM_OFFS_RST;
      intStat   <= 4'h0;
      intEn     <= 4'h0;
      fullPrev  <= 2'h0;
      regRdData <= 32'h0;
    end
    else
    begin
      cfg       <= next_cfg;
      offs      <= next_offs;
      intStat   <= next_intStat;
      intEn     <= next_intEn;
      fullPrev  <= {baFlags.full, abFlags.full};
      regRdData <= next_regRdData;
    end
  end

  assign irq = |(intStat & intEn);

  property p_mail_set;
    @(posedge ref_clk) disable iff (rst)
    aMailWr |=> aToBMailFull && abMail == ($past(aSync2.data) & $past(mailMask));
  endproperty
  a_mail_set: assert property (p_mail_set) else $error("A-to-B mail not stored or flagged"); // see (R15) see (R11)

  property p_mail_clr;
    @(posedge ref_clk) disable iff (rst)
    bMailRd && !aMailWr |=> !aToBMailFull && portbMailData == $past(abMail);
  endproperty
  a_mail_clr: assert property (p_mail_clr) else $error("A-to-B mail read did not clear flag"); // see (R15)

  property p_ready_on_edge;
    @(posedge ref_clk) disable iff (rst)
    $rose(portbInputReady) && $stable(cfg) |-> $past(bEdge);
  endproperty
  a_ready_on_edge: assert property (p_ready_on_edge) else $error("Input ready rose off a B edge"); // see (R1)

  property p_full_on_edge;
    @(posedge ref_clk) disable iff (rst)
    $changed(portbFullFlag) && $stable(cfg) |-> $past(bEdge);
  endproperty
  a_full_on_edge: assert property (p_full_on_edge) else $error("Full flag changed off a B edge"); // see (R2)

  property p_partial_write;
    @(posedge ref_clk) disable iff (rst)
    bWrite && wrPiece != lastIdx && !baFlags.full |-> !baPush ##1 wrPiece != $past(wrPiece);
  endproperty
  a_partial_write: assert property (p_partial_write) else $error("Partial write moved the pointer"); // see (R3)

  property p_ae_set;
    @(posedge ref_clk) disable iff (rst)
    $rose(portbAlmostEmpty) |-> $past(abPop) && $past(rdPiece) == $past(lastIdx);
  endproperty
  a_ae_set: assert property (p_ae_set) else $error("B almost-empty set without a completing read"); // see (R5)

  property p_af_set;
    @(posedge ref_clk) disable iff (rst)
    $rose(portbAlmostFull) |-> $past(baPush);
  endproperty
  a_af_set: assert property (p_af_set) else $error("B almost-full set without a completing write"); // see (R8)

  property p_ae_release;
    @(posedge ref_clk) disable iff (rst)
    $fell(portbAlmostEmpty) |-> $past(bEdge);
  endproperty
  a_ae_release: assert property (p_ae_release) else $error("B almost-empty released off a B edge"); // see (R4)

  property p_byte_mail;
    @(posedge ref_clk) disable iff (rst)
    bSize == bfm_pkg::BFM_BYTE && $stable(bSize) && bMailWr |=> baMail[35:9] == 27'h0;
  endproperty
  a_byte_mail: assert property (p_byte_mail) else $error("B-to-A byte mail has upper bits"); // see (R12)
endmodule
`default_nettype wire

// *** tb/bfm_host_model.sv ***
// Host controller model for ports A and B of the queue flag block.
// Assumes ref_clk runs far faster than the port clocks made here; each access makes one port clock pulse.
`timescale 1ns/10ps
`default_nettype none
module bfm_host_model (
  // Clock
  input  wire logic              ref_clk,
  // Pins towards the device
  output var bfm_pkg::bfm_pins_t pinsA,
  output var bfm_pkg::bfm_pins_t pinsB
);
  initial
  begin
    pinsA = {1'b0, 1'b1, 1'b0, 1'b0, 36'h0};
    pinsB = {1'b0, 1'b1, 1'b0, 1'b0, 36'h0};
  end
  task automatic put(input logic side, input bfm_pkg::bfm_pins_t p);
    if (side)
      pinsB <= p;
    else
      pinsA <= p;
  endtask
  // Controls lead the port clock rise by three cycles and stay four cycles past its fall.
  // The device samples pins through two flops, so a shorter hold would be seen as a different access.
  task automatic access(input logic side, input logic csN, input logic dir, input logic mb, input logic [35:0] d);
    bfm_pkg::bfm_pins_t p;
    @(posedge ref_clk);
    p = {1'b0, csN, dir, mb, d};
    put(side, p);
    repeat (3) @(posedge ref_clk);
    p.clk = 1'b1;
    put(side, p);
    repeat (4) @(posedge ref_clk);
    p.clk = 1'b0;
    put(side, p);
    repeat (4) @(posedge ref_clk);
    // Released lines show the inverse of the last value, so a stale value can never match by chance.
    p.csN = 1'b1;
    p.data = ~d;
    put(side, p);
  endtask
  task automatic idle(input logic side);
    access(side, 1'b1, 1'b0, 1'b0, side ? ~pinsB.data : ~pinsA.data);
  endtask
  task automatic aWrite(input logic mb, input logic [35:0] d);
    access(1'b0, 1'b0, 1'b1, mb, d);
  endtask
  task automatic aRead(input logic mb);
    access(1'b0, 1'b0, 1'b0, mb, ~pinsA.data);
  endtask
  task automatic bWrite(input logic mb, input logic [35:0] d);
    access(1'b1, 1'b0, 1'b0, mb, d);
  endtask
  task automatic bRead(input logic mb);
    access(1'b1, 1'b0, 1'b1, mb, ~pinsB.data);
  endtask
endmodule
`default_nettype wire

// *** tb/test_bfm_top.sv ***
// Self-checking bench for the queue flag block: mailboxes, queue flags, interrupts and the register port.
// Assumes the host model makes every port clock edge and ref_clk runs at 100 MHz.
`timescale 1ns/10ps
`default_nettype none
`include "bfm_regs.svh"
module test_bfm_top;
  logic               ref_clk;
  logic               rst;
  logic [7:0]         regAddr;
  logic [31:0]        regWrData;
  logic               regWr;
  logic               regRd;
  logic [31:0]        regRdData;
  logic               irq;
  logic               busMatchSelect;
  logic               portbSizeSelect;
  logic [35:0]        portaMailData;
  logic [35:0]        portbMailData;
  logic               portaAlmostEmpty, portaAlmostFull, bToAMailFull, aToBMailFull;
  logic               portbInputReady, portbFullFlag, portbAlmostEmpty, portbAlmostFull;
  bfm_pkg::bfm_pins_t pinsA;
  bfm_pkg::bfm_pins_t pinsB;
  int                 errorCnt;
  int                 comparisons;
  bfm_host_model host (
    .ref_clk(ref_clk),
    .pinsA(pinsA),
    .pinsB(pinsB)
  );
  bfm_top dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .regAddr(regAddr),
    .regWrData(regWrData),
    .regWr(regWr),
    .regRd(regRd),
    .regRdData(regRdData),
    .irq(irq),
    .portaClock(pinsA.clk),
    .portaChipSelectN(pinsA.csN),
    .portaDirectionSelect(pinsA.dir),
    .portaMailboxSelect(pinsA.mb),
    .portaData(pinsA.data),
    .portaMailData(portaMailData),
    .portaAlmostEmpty(portaAlmostEmpty),
    .portaAlmostFull(portaAlmostFull),
    .bToAMailFull(bToAMailFull),
    .portbClock(pinsB.clk),
    .portbChipSelectN(pinsB.csN),
    .portbDirectionSelect(pinsB.dir),
    .portbMailboxSelect(pinsB.mb),
    .busMatchSelect(busMatchSelect),
    .portbSizeSelect(portbSizeSelect),
    .portbData(pinsB.data),
    .portbMailData(portbMailData),
    .portbInputReady(portbInputReady),
    .portbFullFlag(portbFullFlag),
    .portbAlmostEmpty(portbAlmostEmpty),
    .portbAlmostFull(portbAlmostFull),
    .aToBMailFull(aToBMailFull)
  );
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] expected);
    comparisons++;
    if (seen !== expected)
    begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", what, expected, seen);
    end
  endtask
  task automatic regWrite(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe, so they are sampled there and nowhere else.
  task automatic regCheck(input string what, input logic [7:0] a, input logic [31:0] expected);
    @(posedge ref_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    check(what, regRdData, expected);
  endtask
  task automatic doReset(input logic bm, input logic sz);
    @(posedge ref_clk);
    rst <= 1'b1;
    busMatchSelect <= bm;
    portbSizeSelect <= sz;
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
  endtask
  task automatic testRegReset;
    regCheck("cfg", `BFM_ADDR_CFG, `BFM_CFG_RST);
    regCheck("offs", `BFM_ADDR_OFFS, `BFM_OFFS_RST);
    regCheck("int_en", `BFM_ADDR_INT_EN, 32'h0);
    regWrite(8'h40, 32'hffff_ffff);
    regCheck("unmapped", 8'h40, 32'h0);
    regCheck("status", `BFM_ADDR_STATUS, 32'hc);
    check("portbAlmostEmpty", portbAlmostEmpty, 1'b1);
    check("portaAlmostEmpty", portaAlmostEmpty, 1'b1);
    // The reset depth of 1024 is only reached here, on the A-to-B almost-full threshold.
    repeat (1015) host.aWrite(1'b0, 36'h0);
    check("portaAlmostFull deep below", portaAlmostFull, 1'b0);
    host.aWrite(1'b0, 36'h0);
    check("portaAlmostFull deep", portaAlmostFull, 1'b1);
    $display("test register reset done");
  endtask
  task automatic testMail;
    logic [35:0] mask [3];
    mask = '{`BFM_LONG_MASK, `BFM_WORD_MASK, `BFM_BYTE_MASK};
    for (int i = 0; i < 3; i++)
    begin
      doReset(i != 0, i == 2);
      regWrite(`BFM_ADDR_INT_EN, 32'h3);
      host.aWrite(1'b1, 36'hf_ffff_fff0);
      check("aToBMailFull", aToBMailFull, 1'b1);
      check("irq", irq, 1'b1);
      host.bRead(1'b1);
      check("portbMailData", portbMailData, mask[i] & 36'hf_ffff_fff0);
      check("aToBMailFull", aToBMailFull, 1'b0);
      host.bWrite(1'b1, 36'ha_5a5a_5a5a);
      check("bToAMailFull", bToAMailFull, 1'b1);
      host.aRead(1'b1);
      check("portaMailData", portaMailData, mask[i] & 36'ha_5a5a_5a5a);
      check("bToAMailFull", bToAMailFull, 1'b0);
      regCheck("int_stat", `BFM_ADDR_INT_STAT, 32'h3);
      regWrite(`BFM_ADDR_INT_EN, 32'h0);
      check("irq masked", irq, 1'b0);
      regWrite(`BFM_ADDR_INT_CLR, 32'h1);
      regCheck("int_stat cleared", `BFM_ADDR_INT_STAT, 32'h2);
    end
    $display("test mailboxes done");
  endtask
  task automatic testFullStd;
    doReset(1'b1, 1'b0);
    regWrite(`BFM_ADDR_CFG, 32'h0);
    repeat (17) host.bWrite(1'b0, 36'h0);
    repeat (2) host.idle(1'b0);
    check("portaAlmostEmpty half", portaAlmostEmpty, 1'b1);
    host.bWrite(1'b0, 36'h0);
    check("portaAlmostEmpty before edge", portaAlmostEmpty, 1'b1);
    repeat (2) host.idle(1'b0);
    check("portaAlmostEmpty", portaAlmostEmpty, 1'b0);
    repeat (477) host.bWrite(1'b0, 36'h0);
    check("portbAlmostFull half", portbAlmostFull, 1'b0);
    host.bWrite(1'b0, 36'h0);
    check("portbAlmostFull", portbAlmostFull, 1'b1);
    repeat (15) host.bWrite(1'b0, 36'h0);
    check("portbFullFlag half", portbFullFlag, 1'b0);
    host.bWrite(1'b0, 36'h0);
    check("portbFullFlag", portbFullFlag, 1'b1);
    check("portbInputReady std", portbInputReady, 1'b0);
    regCheck("int_stat full", `BFM_ADDR_INT_STAT, 32'h8);
    host.aRead(1'b0);
    check("portbFullFlag before edge", portbFullFlag, 1'b1);
    repeat (2) host.idle(1'b1);
    check("portbFullFlag released", portbFullFlag, 1'b0);
    repeat (7) host.aRead(1'b0);
    repeat (2) host.idle(1'b1);
    check("portbAlmostFull kept", portbAlmostFull, 1'b1);
    host.aRead(1'b0);
    repeat (2) host.idle(1'b1);
    check("portbAlmostFull released", portbAlmostFull, 1'b0);
    $display("test full standard word done");
  endtask
  task automatic testFullFallThrough;
    doReset(1'b0, 1'b0);
    regWrite(`BFM_ADDR_CFG, 32'h1);
    repeat (256) host.bWrite(1'b0, 36'h0);
    check("portbInputReady full", portbInputReady, 1'b0);
    check("portbFullFlag fall-through", portbFullFlag, 1'b0);
    host.bWrite(1'b0, 36'h0);
    // The A-side empty flag refreshes only on an A edge, so an idle edge must precede the first read.
    host.idle(1'b0);
    host.aRead(1'b0);
    check("portbInputReady before edge", portbInputReady, 1'b0);
    repeat (2) host.idle(1'b1);
    check("portbInputReady", portbInputReady, 1'b1);
    $display("test full fall-through done");
  endtask
  task automatic testAToB;
    doReset(1'b1, 1'b1);
    regWrite(`BFM_ADDR_CFG, 32'h2);
    repeat (9) host.aWrite(1'b0, 36'h0);
    check("portbAlmostEmpty before edge", portbAlmostEmpty, 1'b1);
    repeat (2) host.idle(1'b1);
    check("portbAlmostEmpty", portbAlmostEmpty, 1'b0);
    repeat (3) host.bRead(1'b0);
    check("portbAlmostEmpty part", portbAlmostEmpty, 1'b0);
    host.bRead(1'b0);
    check("portbAlmostEmpty last", portbAlmostEmpty, 1'b1);
    repeat (495) host.aWrite(1'b0, 36'h0);
    check("portaAlmostFull below", portaAlmostFull, 1'b0);
    host.aWrite(1'b0, 36'h0);
    check("portaAlmostFull", portaAlmostFull, 1'b1);
    repeat (3) host.bRead(1'b0);
    repeat (2) host.idle(1'b0);
    check("portaAlmostFull part", portaAlmostFull, 1'b1);
    host.bRead(1'b0);
    repeat (2) host.idle(1'b0);
    check("portaAlmostFull released", portaAlmostFull, 1'b0);
    $display("test A to B flags done");
  endtask
  task automatic giveVerdict;
    $display("comparisons %0d mismatches %0d", comparisons, errorCnt);
    if (errorCnt == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // The tests take about 30 k cycles; a limit of 60 k cycles leaves ample margin.
  initial
  begin
    #600000;
    errorCnt++;
    $display("watchdog expired");
    giveVerdict;
  end
  initial
  begin
    rst = 1'b1;
    regAddr = 8'h0;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    busMatchSelect = 1'b0;
    portbSizeSelect = 1'b0;
    errorCnt = 0;
    comparisons = 0;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    testRegReset;
    testMail;
    testFullStd;
    testFullFallThrough;
    testAToB;
    giveVerdict;
  end
endmodule
`default_nettype wire
